// ===== rtl/rfc_top.sv
`timescale 1ns/1ns
module rfc_top #(
    parameter int CNT_W = 16
) (
    input wire logic I_CLK_SYS, // 25 MHz system clock
    input wire logic I_RESET, // async reset, active high
    input wire logic [7:0] I_AXI_AWADDR, // write address
    input wire logic I_AXI_AWVALID, // write address valid
    output logic O_AXI_AWREADY, // write address ready
    input wire logic [31:0] I_AXI_WDATA, // write data
    input wire logic [3:0] I_AXI_WSTRB, // write byte strobes
    input wire logic I_AXI_WVALID, // write data valid
    output logic O_AXI_WREADY, // write data ready
    output logic [1:0] O_AXI_BRESP, // write response
    output logic O_AXI_BVALID, // write response valid
    input wire logic I_AXI_BREADY, // write response ready
    input wire logic [7:0] I_AXI_ARADDR, // read address
    input wire logic I_AXI_ARVALID, // read address valid
    output logic O_AXI_ARREADY, // read address ready
    output logic [31:0] O_AXI_RDATA, // read data
    output logic [1:0] O_AXI_RRESP, // read response
    output logic O_AXI_RVALID, // read data valid
    input wire logic I_AXI_RREADY, // read data ready
    input wire logic I_EXT_OSC_INPUT_0, // converter oscillator 0 output
    input wire logic I_EXT_OSC_INPUT_1, // converter oscillator 1 output
    input wire logic I_AUX_LOW_SPEED_OSC, // auxiliary oscillator output
    output logic O_AUX_OSC_ENABLE, // runs auxiliary oscillator
    output logic O_NETWORK_SELECT, // 1 = sensor resistor network
    output logic O_OSC_CHANNEL_SELECT, // 1 = oscillator channel 1
    output logic O_IRQ // level interrupt
);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    logic [7:0] conv_cfg_q;
    logic [7:0] tmr_ctrl_q;
    logic [CNT_W-1:0] tmr_a_q;
    logic [CNT_W-1:0] tmr_b_q;
    localparam int IRQ_W_L = rfc_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] irq_stat_q;
    logic [IRQ_W_L-1:0] irq_mask_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_held_q;
    logic w_held_q;
    logic do_wr;
    logic in_prev_q;
    logic aux_prev_q;
    logic irq_q;
    rfc_pkg::rfc_pw_state_t pw_q;
    rfc_pkg::rfc_ctrl_t c;
    logic sel_in;
    logic in_rise;
    logic in_fall;
    logic aux_rise;
    logic ev_tick;
    logic a_tick;
    logic b_tick;
    logic ovf_a;
    logic ovf_b;
    logic conv_ovf;
    logic tmr_ovf;
    logic pw_start;
    logic pw_stop;
    logic hw_stop;
    logic wr_cfg;
    logic wr_ctrl;
    logic wr_a;
    logic wr_b;
    logic wr_stat;
    logic wr_mask;
    logic cnt_locked;
    logic [CNT_W-1:0] wr_cnt;
    logic [IRQ_W_L-1:0] irq_set;
    logic [31:0] rd_word;

    // word-aligned match of a bus address against a register offset
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = ({addr[7:2], 2'b00} == off);
    endfunction : hit

    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, rfc_pkg::OFF_CONV_CFG) | hit(addr, rfc_pkg::OFF_TMR_CTRL)
               | hit(addr, rfc_pkg::OFF_TMR_A) | hit(addr, rfc_pkg::OFF_TMR_B)
               | hit(addr, rfc_pkg::OFF_IRQ_STAT) | hit(addr, rfc_pkg::OFF_IRQ_MASK);
    endfunction : mapped

    // byte-lane merge of a bus word into a register
    function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        logic [CNT_W-1:0] r;
        r = old;
        for (int i = 0; i < CNT_W / 8; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // decode of the two control registers
    always_comb begin
        c.ch_sel = conv_cfg_q[rfc_pkg::CFG_CH_SEL];
        c.tmb_clk = conv_cfg_q[rfc_pkg::CFG_TMB_CLK];
        c.aux_en = conv_cfg_q[rfc_pkg::CFG_AUX_EN];
        c.net_sel = conv_cfg_q[rfc_pkg::CFG_NET_SEL];
        c.conv_mode = conv_cfg_q[rfc_pkg::CFG_CONV_MODE];
        c.ovf_src = conv_cfg_q[rfc_pkg::CFG_OVF_SRC];
        c.mode = rfc_pkg::rfc_tmode_t'(tmr_ctrl_q[rfc_pkg::TMC_MODE_LO +: 2]);
        c.enable = tmr_ctrl_q[rfc_pkg::TMC_EN];
        c.edge_sel = tmr_ctrl_q[rfc_pkg::TMC_EDGE];
    end

    // input selection and edge detection; a change of channel may look like one edge
    assign sel_in = c.ch_sel ? I_EXT_OSC_INPUT_1 : I_EXT_OSC_INPUT_0;
    assign in_rise = sel_in & ~in_prev_q;
    assign in_fall = ~sel_in & in_prev_q;
    assign aux_rise = I_AUX_LOW_SPEED_OSC & ~aux_prev_q & c.aux_en; // stopped oscillator gives no edges
    assign ev_tick = c.edge_sel ? in_fall : in_rise;

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            in_prev_q <= 1'b0;
            aux_prev_q <= 1'b0;
        end else begin
            in_prev_q <= sel_in;
            aux_prev_q <= I_AUX_LOW_SPEED_OSC;
        end
    end

    // clock enables of both counters per mode
    always_comb begin
        case (c.mode)
            rfc_pkg::MODE_EVENT: a_tick = ev_tick;
            rfc_pkg::MODE_TIMER: a_tick = 1'b1;
            rfc_pkg::MODE_PULSE: a_tick = (pw_q == rfc_pkg::PW_RUN) && !c.conv_mode;
            rfc_pkg::MODE_UNUSED: a_tick = 1'b0;
            default: a_tick = 1'b0;
        endcase
        a_tick = a_tick & c.enable;
        b_tick = c.enable & c.conv_mode & (c.tmb_clk ? in_rise : aux_rise);
    end

    assign ovf_a = a_tick && (tmr_a_q == CNT_MAX);
    assign ovf_b = b_tick && (tmr_b_q == CNT_MAX);
    assign conv_ovf = c.conv_mode && (c.ovf_src ? ovf_b : ovf_a);
    assign tmr_ovf = !c.conv_mode && ovf_a;
    // pulse mode: edge_sel 1 starts on rising and stops on falling, 0 the other way
    assign pw_start = c.edge_sel ? in_rise : in_fall;
    assign pw_stop = c.edge_sel ? in_fall : in_rise;
    assign hw_stop = conv_ovf
                   || (!c.conv_mode && c.mode == rfc_pkg::MODE_PULSE && pw_q == rfc_pkg::PW_RUN && pw_stop);
    assign irq_set = {hw_stop & ~conv_ovf, conv_ovf | tmr_ovf};

    // pulse width measurement: one measurement per setting of the enable bit
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            pw_q <= rfc_pkg::PW_WAIT;
        end else begin
            case (pw_q)
                rfc_pkg::PW_WAIT: begin
                    if (c.enable && !c.conv_mode && c.mode == rfc_pkg::MODE_PULSE && pw_start) begin
                        pw_q <= rfc_pkg::PW_RUN;
                    end
                end
                rfc_pkg::PW_RUN: begin
                    if (pw_stop || !c.enable || c.conv_mode || c.mode != rfc_pkg::MODE_PULSE) begin
                        pw_q <= rfc_pkg::PW_WAIT;
                    end
                end
                default: pw_q <= rfc_pkg::PW_WAIT;
            endcase
        end
    end

    // write decode; counters are locked while the converter runs
    assign do_wr = aw_held_q & w_held_q & ~O_AXI_BVALID;
    assign cnt_locked = c.conv_mode & c.enable;
    assign wr_cfg = do_wr & hit(awaddr_q, rfc_pkg::OFF_CONV_CFG) & wstrb_q[0];
    assign wr_ctrl = do_wr & hit(awaddr_q, rfc_pkg::OFF_TMR_CTRL) & wstrb_q[0];
    assign wr_a = do_wr & hit(awaddr_q, rfc_pkg::OFF_TMR_A) & ~cnt_locked;
    assign wr_b = do_wr & hit(awaddr_q, rfc_pkg::OFF_TMR_B) & ~cnt_locked;
    assign wr_stat = do_wr & hit(awaddr_q, rfc_pkg::OFF_IRQ_STAT) & wstrb_q[0];
    assign wr_mask = do_wr & hit(awaddr_q, rfc_pkg::OFF_IRQ_MASK) & wstrb_q[0];
    assign wr_cnt = merge(tmr_b_q, wdata_q, wstrb_q);

    // converter configuration register
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            conv_cfg_q <= rfc_pkg::CONV_CFG_RST; // auxiliary oscillator off
        end else if (wr_cfg) begin
            conv_cfg_q <= wdata_q[7:0] & rfc_pkg::CONV_CFG_MASK;
        end
    end

    // timer control; hardware clears the enable at the end of a run, a write wins
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            tmr_ctrl_q <= rfc_pkg::TMR_CTRL_RST;
        end else if (wr_ctrl) begin
            tmr_ctrl_q <= wdata_q[7:0] & rfc_pkg::TMR_CTRL_MASK; // bit 7 and 2..0 stay 0
        end else if (hw_stop) begin
            tmr_ctrl_q[rfc_pkg::TMC_EN] <= 1'b0;
        end
    end

    // counters: two up counters in converter mode, counter plus preload otherwise
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            tmr_a_q <= '0;
            tmr_b_q <= '0;
        end else if (c.conv_mode) begin
            if (wr_a) begin
                tmr_a_q <= merge(tmr_a_q, wdata_q, wstrb_q);
            end else if (a_tick) begin
                tmr_a_q <= tmr_a_q + 1'b1;
            end
            if (wr_b) begin
                tmr_b_q <= wr_cnt;
            end else if (b_tick) begin
                tmr_b_q <= tmr_b_q + 1'b1;
            end
        end else begin
            if (wr_b) begin
                tmr_b_q <= wr_cnt;
            end
            if (wr_b && !c.enable) begin
                tmr_a_q <= wr_cnt; // stopped counter also takes the preload
            end else if (wr_a && !c.enable) begin
                tmr_a_q <= merge(tmr_a_q, wdata_q, wstrb_q);
            end else if (ovf_a) begin
                tmr_a_q <= tmr_b_q; // reload on overflow
            end else if (a_tick) begin
                tmr_a_q <= tmr_a_q + 1'b1;
            end
        end
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            irq_stat_q <= rfc_pkg::IRQ_RST;
            irq_mask_q <= rfc_pkg::IRQ_RST;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? wdata_q[IRQ_W_L-1:0] : '0)) | irq_set;
            if (wr_mask) begin
                irq_mask_q <= wdata_q[IRQ_W_L-1:0];
            end
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // write channels: address and data taken in either order, answer two cycles after both
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            O_AXI_BVALID <= 1'b0;
            O_AXI_BRESP <= rfc_pkg::RESP_OKAY;
            O_AXI_AWREADY <= 1'b1;
            O_AXI_WREADY <= 1'b1;
        end else begin
            // readies are kept as their own flops so the pins carry no gate after the register
            if (!aw_held_q && I_AXI_AWVALID) begin
                aw_held_q <= 1'b1;
                awaddr_q <= I_AXI_AWADDR;
                O_AXI_AWREADY <= 1'b0;
            end
            if (!w_held_q && I_AXI_WVALID) begin
                w_held_q <= 1'b1;
                wdata_q <= I_AXI_WDATA;
                wstrb_q <= I_AXI_WSTRB;
                O_AXI_WREADY <= 1'b0;
            end
            if (do_wr) begin
                O_AXI_BVALID <= 1'b1;
                O_AXI_BRESP <= mapped(awaddr_q) ? rfc_pkg::RESP_OKAY : rfc_pkg::RESP_SLVERR;
            end else if (O_AXI_BVALID && I_AXI_BREADY) begin
                O_AXI_BVALID <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                O_AXI_AWREADY <= 1'b1;
                O_AXI_WREADY <= 1'b1;
            end
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit(I_AXI_ARADDR, rfc_pkg::OFF_CONV_CFG)) rd_word[7:0] = conv_cfg_q;
        if (hit(I_AXI_ARADDR, rfc_pkg::OFF_TMR_CTRL)) rd_word[7:0] = tmr_ctrl_q;
        if (hit(I_AXI_ARADDR, rfc_pkg::OFF_TMR_A)) rd_word[CNT_W-1:0] = tmr_a_q;
        if (hit(I_AXI_ARADDR, rfc_pkg::OFF_TMR_B)) rd_word[CNT_W-1:0] = tmr_b_q;
        if (hit(I_AXI_ARADDR, rfc_pkg::OFF_IRQ_STAT)) rd_word[IRQ_W_L-1:0] = irq_stat_q;
        if (hit(I_AXI_ARADDR, rfc_pkg::OFF_IRQ_MASK)) rd_word[IRQ_W_L-1:0] = irq_mask_q;
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            O_AXI_ARREADY <= 1'b1;
            O_AXI_RVALID <= 1'b0;
            O_AXI_RDATA <= 32'h0000_0000;
            O_AXI_RRESP <= rfc_pkg::RESP_OKAY;
        end else if (O_AXI_ARREADY && I_AXI_ARVALID) begin
            O_AXI_ARREADY <= 1'b0;
            O_AXI_RVALID <= 1'b1;
            O_AXI_RDATA <= rd_word;
            O_AXI_RRESP <= mapped(I_AXI_ARADDR) ? rfc_pkg::RESP_OKAY : rfc_pkg::RESP_SLVERR;
        end else if (O_AXI_RVALID && I_AXI_RREADY) begin
            O_AXI_RVALID <= 1'b0;
            O_AXI_ARREADY <= 1'b1;
        end
    end

    // analog controls come straight from the configuration flops
    assign O_AUX_OSC_ENABLE = conv_cfg_q[rfc_pkg::CFG_AUX_EN];
    assign O_NETWORK_SELECT = conv_cfg_q[rfc_pkg::CFG_NET_SEL];
    assign O_OSC_CHANNEL_SELECT = conv_cfg_q[rfc_pkg::CFG_CH_SEL];
    assign O_IRQ = irq_q;
endmodule : rfc_top

// ===== rtl/rfc_pkg.sv
package rfc_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFF_CONV_CFG = 8'h00;
    localparam logic [7:0] OFF_TMR_CTRL = 8'h04;
    localparam logic [7:0] OFF_TMR_A = 8'h08;
    localparam logic [7:0] OFF_TMR_B = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    // reset values and writable-bit masks
    localparam logic [7:0] CONV_CFG_RST = 8'h00;
    localparam logic [7:0] CONV_CFG_MASK = 8'hE7;
    localparam logic [7:0] TMR_CTRL_RST = 8'h08;
    localparam logic [7:0] TMR_CTRL_MASK = 8'h78;
    // converter_config field positions
    localparam int CFG_CH_SEL = 7;
    localparam int CFG_TMB_CLK = 6;
    localparam int CFG_AUX_EN = 5;
    localparam int CFG_NET_SEL = 2;
    localparam int CFG_CONV_MODE = 1;
    localparam int CFG_OVF_SRC = 0;
    // timer_control field positions
    localparam int TMC_MODE_LO = 5;
    localparam int TMC_EN = 4;
    localparam int TMC_EDGE = 3;
    // interrupt status and mask bits
    localparam int IRQ_W = 2;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_PULSE = 1;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_UNUSED = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_TIMER = 2'b10,
        MODE_PULSE = 2'b11
    } rfc_tmode_t;

    typedef enum logic [0:0] {
        PW_WAIT = 1'b0,
        PW_RUN = 1'b1
    } rfc_pw_state_t;

    // decoded control fields
    typedef struct packed {
        logic ch_sel;
        logic tmb_clk;
        logic aux_en;
        logic net_sel;
        logic conv_mode;
        logic ovf_src;
        rfc_tmode_t mode;
        logic enable;
        logic edge_sel;
    } rfc_ctrl_t;
endpackage : rfc_pkg

// ===== bench/rfc_osc_net.sv
`timescale 1ns/1ns
module rfc_osc_net (
    input wire logic i_clk, // system clock
    input wire logic i_aux_en, // auxiliary oscillator run request
    input wire logic i_net_sel, // 1 = sensor network
    output logic o_osc_0, // converter oscillator 0
    output logic o_osc_1, // converter oscillator 1
    output logic o_aux // auxiliary oscillator
);
    int cnt_q = 0;
    int aux_q = 0;
    initial begin
        o_osc_0 = 1'b0;
        o_osc_1 = 1'b0;
        o_aux = 1'b0;
    end
    // sensor network swings faster than the reference one, so the rate shows which is chosen
    always @(posedge i_clk) begin
        cnt_q <= cnt_q + 1;
        if (cnt_q % (i_net_sel ? 3 : 5) == 0) o_osc_0 <= ~o_osc_0;
        if (cnt_q % (i_net_sel ? 4 : 6) == 0) o_osc_1 <= ~o_osc_1;
    end
    // a stopped oscillator stands still low instead of holding its last level
    always @(posedge i_clk) begin
        aux_q <= i_aux_en ? aux_q + 1 : 0;
        o_aux <= i_aux_en ? (aux_q % 14 >= 7) : 1'b0;
    end
endmodule : rfc_osc_net

// ===== bench/rfc_top_assertions.sv
`timescale 1ns/1ns
module rfc_top_chk (
    input wire logic I_CLK_SYS, // clock
    input wire logic I_RESET, // reset
    input wire logic [7:0] I_AXI_AWADDR, // write address
    input wire logic I_AXI_AWVALID, // write address valid
    input wire logic O_AXI_AWREADY, // write address ready
    input wire logic [31:0] I_AXI_WDATA, // write data
    input wire logic I_AXI_WVALID, // write data valid
    input wire logic O_AXI_WREADY, // write data ready
    input wire logic O_AXI_BVALID, // write response valid
    input wire logic [7:0] I_AXI_ARADDR, // read address
    input wire logic I_AXI_ARVALID, // read address valid
    input wire logic O_AXI_ARREADY, // read address ready
    input wire logic [31:0] O_AXI_RDATA, // read data
    input wire logic [1:0] O_AXI_RRESP, // read response
    input wire logic O_AXI_RVALID, // read valid
    input wire logic O_AUX_OSC_ENABLE, // aux enable
    input wire logic O_NETWORK_SELECT, // network select
    input wire logic O_OSC_CHANNEL_SELECT, // channel select
    input wire logic O_IRQ // interrupt
);
    logic wr_hs;
    logic cfg_wr;
    logic [7:0] cfg_q;
    logic [7:0] mask_q;
    logic [7:0] rd_addr_q;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);
    // both write channels are offered together, so one handshake edge takes them
    assign wr_hs = I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY;
    assign cfg_wr = wr_hs && I_AXI_AWADDR[7:2] == 6'h00;
    sequence s_wr_hs;
        wr_hs;
    endsequence
    // shadow copies of what software last wrote and where it last read
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            cfg_q <= 8'h00;
            mask_q <= 8'h00;
            rd_addr_q <= 8'h00;
        end else begin
            if (cfg_wr) cfg_q <= I_AXI_WDATA[7:0];
            if (wr_hs && I_AXI_AWADDR[7:2] == 6'h05) mask_q <= I_AXI_WDATA[7:0];
            if (I_AXI_ARVALID && O_AXI_ARREADY) rd_addr_q <= I_AXI_ARADDR;
        end
    end
    chk_bresp_after_write: assert property (s_wr_hs |-> ##[1:2] O_AXI_BVALID)
        else $error("write response late");
    chk_rvalid_after_ar: assert property (I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID)
        else $error("read data late");
    chk_pins_after_reset: assert property ($fell(I_RESET) |-> !O_AUX_OSC_ENABLE && !O_NETWORK_SELECT && !O_OSC_CHANNEL_SELECT)
        else $error("pin not low after reset");
    chk_aux_follows_cfg: assert property (cfg_wr |=> ##[0:2] O_AUX_OSC_ENABLE == cfg_q[5])
        else $error("aux enable pin wrong");
    chk_net_follows_cfg: assert property (cfg_wr |=> ##[0:2] O_NETWORK_SELECT == cfg_q[2])
        else $error("network pin wrong");
    chk_chan_follows_cfg: assert property (cfg_wr |=> ##[0:2] O_OSC_CHANNEL_SELECT == cfg_q[7])
        else $error("channel pin wrong");
    chk_cfg_gaps_zero: assert property (O_AXI_RVALID && rd_addr_q[7:2] == 6'h00 |-> O_AXI_RDATA[31:8] == 24'h0 && O_AXI_RDATA[4:3] == 2'h0)
        else $error("config gap bits not zero");
    chk_tmc_gaps_zero: assert property (O_AXI_RVALID && rd_addr_q[7:2] == 6'h01 |-> O_AXI_RDATA[31:7] == 25'h0 && O_AXI_RDATA[2:0] == 3'h0)
        else $error("timer control gap bits not zero");
    chk_unmapped_read: assert property (O_AXI_RVALID && rd_addr_q >= 8'h18 |-> O_AXI_RRESP == rfc_pkg::RESP_SLVERR && O_AXI_RDATA == 32'h0)
        else $error("unmapped read answered");
    chk_irq_needs_mask: assert property (O_IRQ |-> mask_q != 8'h00 || $past(mask_q) != 8'h00 || $past(mask_q, 2) != 8'h00)
        else $error("interrupt while masked");
endmodule : rfc_top_chk
bind rfc_top rfc_top_chk chk_u (.I_CLK_SYS, .I_RESET, .I_AXI_AWADDR, .I_AXI_AWVALID, .O_AXI_AWREADY, .I_AXI_WDATA,
    .I_AXI_WVALID, .O_AXI_WREADY, .O_AXI_BVALID, .I_AXI_ARADDR, .I_AXI_ARVALID, .O_AXI_ARREADY, .O_AXI_RDATA,
    .O_AXI_RRESP, .O_AXI_RVALID, .O_AUX_OSC_ENABLE, .O_NETWORK_SELECT, .O_OSC_CHANNEL_SELECT, .O_IRQ);

// ===== bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] aw_a = 8'h00;
    logic [7:0] ar_a = 8'h00;
    logic [31:0] w_d = 32'h0;
    logic aw_v = 1'b0;
    logic w_v = 1'b0;
    logic ar_v = 1'b0;
    logic awr, wr, arr, bv, rv, aux_en, net, chs, irq, osc0, osc1, aux;
    logic [1:0] br, rr;
    logic [31:0] rd, v;
    logic [1:0] r;
    int n_fail = 0;
    int num_checks = 0;
    rfc_top dut_u (.I_CLK_SYS(clk), .I_RESET(rst), .I_AXI_AWADDR(aw_a), .I_AXI_AWVALID(aw_v), .O_AXI_AWREADY(awr),
        .I_AXI_WDATA(w_d), .I_AXI_WSTRB(4'hF), .I_AXI_WVALID(w_v), .O_AXI_WREADY(wr), .O_AXI_BRESP(br),
        .O_AXI_BVALID(bv), .I_AXI_BREADY(1'b1), .I_AXI_ARADDR(ar_a), .I_AXI_ARVALID(ar_v), .O_AXI_ARREADY(arr),
        .O_AXI_RDATA(rd), .O_AXI_RRESP(rr), .O_AXI_RVALID(rv), .I_AXI_RREADY(1'b1), .I_EXT_OSC_INPUT_0(osc0),
        .I_EXT_OSC_INPUT_1(osc1), .I_AUX_LOW_SPEED_OSC(aux), .O_AUX_OSC_ENABLE(aux_en), .O_NETWORK_SELECT(net),
        .O_OSC_CHANNEL_SELECT(chs), .O_IRQ(irq));
    rfc_osc_net osc_u (.i_clk(clk), .i_aux_en(aux_en), .i_net_sel(net), .o_osc_0(osc0), .o_osc_1(osc1), .o_aux(aux));
    // 25 MHz system clock
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk
    // address and data offered together, each dropped once its own ready was seen
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_v && awr === 1'b1) aw_v <= 1'b0;
            if (w_v && wr === 1'b1) w_v <= 1'b0;
        end while ((aw_v && awr !== 1'b1) || (w_v && wr !== 1'b1));
        do @(posedge clk); while (bv !== 1'b1);
        chk(32'(br), 32'(rfc_pkg::RESP_OKAY));
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
        ar_a <= a;
        ar_v <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        ar_v <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        d = rd;
        s = rr;
    endtask : rd_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a, v, r);
        chk(v, exp);
    endtask : rd_chk
    task automatic wait_ovf();
        do rd_reg(rfc_pkg::OFF_IRQ_STAT, v, r); while (v[0] !== 1'b1);
    endtask : wait_ovf
    task automatic conclude();
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // a hang counts as a mismatch
    initial begin
        #(40 * 20000);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(rfc_pkg::OFF_CONV_CFG, 32'h00);
        rd_chk(rfc_pkg::OFF_TMR_CTRL, 32'h08);
        rd_chk(rfc_pkg::OFF_IRQ_STAT, 32'h00);
        rd_chk(rfc_pkg::OFF_IRQ_MASK, 32'h00);
        chk(32'({aux_en, net, chs}), 32'h0);
        wr_reg(rfc_pkg::OFF_CONV_CFG, 32'hFFFFFFFF);
        rd_chk(rfc_pkg::OFF_CONV_CFG, 32'hE7);
        chk(32'({aux_en, net, chs}), 32'h7);
        wr_reg(rfc_pkg::OFF_TMR_CTRL, 32'hFFFFFF87);
        rd_chk(rfc_pkg::OFF_TMR_CTRL, 32'h00);
        rd_reg(8'h18, v, r);
        chk(v, 32'h0);
        chk(32'(r), 32'(rfc_pkg::RESP_SLVERR));
        // single timer: counts every cycle, reloads from timer B on overflow
        wr_reg(rfc_pkg::OFF_CONV_CFG, 32'h00);
        wr_reg(rfc_pkg::OFF_TMR_B, 32'hFFF0);
        wr_reg(rfc_pkg::OFF_IRQ_MASK, 32'h01);
        wr_reg(rfc_pkg::OFF_TMR_CTRL, 32'h50);
        wait_ovf();
        chk(32'(irq), 32'h1);
        wr_reg(rfc_pkg::OFF_TMR_CTRL, 32'h40);
        rd_reg(rfc_pkg::OFF_TMR_A, v, r);
        chk(v & 32'hFFF0, 32'hFFF0);
        rd_chk(rfc_pkg::OFF_TMR_B, 32'hFFF0);
        wr_reg(rfc_pkg::OFF_IRQ_STAT, 32'h01);
        rd_chk(rfc_pkg::OFF_IRQ_STAT, 32'h00);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        // unused mode must leave the counter alone
        wr_reg(rfc_pkg::OFF_TMR_B, 32'h1234);
        wr_reg(rfc_pkg::OFF_TMR_CTRL, 32'h10);
        repeat (20) @(posedge clk);
        rd_chk(rfc_pkg::OFF_TMR_A, 32'h1234);
        // event mode counts rising edges of oscillator 0 only; stop first so the preload reaches timer A
        wr_reg(rfc_pkg::OFF_TMR_CTRL, 32'h20);
        wr_reg(rfc_pkg::OFF_TMR_B, 32'h0);
        wr_reg(rfc_pkg::OFF_TMR_CTRL, 32'h30);
        repeat (40) @(posedge clk);
        wr_reg(rfc_pkg::OFF_TMR_CTRL, 32'h20);
        rd_reg(rfc_pkg::OFF_TMR_A, v, r);
        chk(32'(v >= 4 && v <= 5), 32'h1);
        // pulse width: one high phase of oscillator 0 is five cycles, then the enable drops
        wr_reg(rfc_pkg::OFF_TMR_B, 32'h0);
        wr_reg(rfc_pkg::OFF_TMR_CTRL, 32'h78);
        repeat (30) @(posedge clk);
        rd_chk(rfc_pkg::OFF_TMR_CTRL, 32'h68);
        rd_chk(rfc_pkg::OFF_TMR_A, 32'h5);
        rd_chk(rfc_pkg::OFF_IRQ_STAT, 32'h2);
        // converter, timer B on the auxiliary oscillator overflows first
        wr_reg(rfc_pkg::OFF_CONV_CFG, 32'h23);
        wr_reg(rfc_pkg::OFF_TMR_B, 32'hFFFC);
        wr_reg(rfc_pkg::OFF_TMR_A, 32'h0);
        wr_reg(rfc_pkg::OFF_TMR_CTRL, 32'h50);
        wait_ovf();
        rd_chk(rfc_pkg::OFF_TMR_CTRL, 32'h40);
        rd_chk(rfc_pkg::OFF_TMR_B, 32'h0);
        rd_reg(rfc_pkg::OFF_TMR_A, v, r);
        chk(32'(v != 0), 32'h1);
        wr_reg(rfc_pkg::OFF_IRQ_STAT, 32'h01);
        // converter, timer B on the converter oscillator, timer A overflow stops both
        wr_reg(rfc_pkg::OFF_CONV_CFG, 32'h42);
        wr_reg(rfc_pkg::OFF_TMR_B, 32'h0);
        wr_reg(rfc_pkg::OFF_TMR_A, 32'hFFE0);
        wr_reg(rfc_pkg::OFF_TMR_CTRL, 32'h50);
        wait_ovf();
        rd_chk(rfc_pkg::OFF_TMR_CTRL, 32'h40);
        rd_chk(rfc_pkg::OFF_TMR_A, 32'h0);
        rd_reg(rfc_pkg::OFF_TMR_B, v, r);
        chk(32'(v != 0), 32'h1);
        // masked status must not raise the interrupt
        wr_reg(rfc_pkg::OFF_IRQ_MASK, 32'h00);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        conclude();
    end
endmodule : tb_top
